// ---- rtl/serial_in_parallel_out_latch.v ----
// Summary of operation
// - shift and store only on rising shift and storage edges
// - eight shift stages feed eight-bit storage register
// - shift: first stage takes serial_in, others shift
// - low clear forces all shift stages zero
// - storage edge copies all shift stages
// - enable high floats parallel outputs
// - shared edge stores pre-shift value
//
// Purpose: serial-in shift register feeding a parallel storage register
// Assumes: all inputs synchronous to clk_in; clocks are sampled levels
// Notes:   stored words also queue in a FIFO for a downstream reader
`timescale 1ns/1ps
`include "sipo_latch_defines.vh"
module serial_in_parallel_out_latch #(
	parameter STAGES = `STAGE_COUNT,
	parameter DEPTH  = `FIFO_DEPTH
) (
	// clock and reset
	input  wire              clk_in,
	input  wire              srst_in,
	// serial side
	input  wire              shift_clock_in,
	input  wire              serial_in_in,
	input  wire              shift_clear_n_in,
	input  wire              storage_clock_in,
	input  wire              output_enable_n_in,
	output wire              cascade_serial_out_out,
	// parallel pins
	output wire [STAGES-1:0] parallel_out_out,
	output wire [STAGES-1:0] parallel_oe_out,
	// stored word stream
	output wire              word_valid_out,
	input  wire              word_ready_in,
	output wire [STAGES-1:0] word_data_out,
	output wire              word_dropped_out
);
	// ------------------------------------------------------------
	// edge detection
	// ------------------------------------------------------------
	wire shift_rise;
	wire store_rise;
	wire fifo_in_ready;

	edge_detect u_shift_edge (
		.clk_in  (clk_in),
		.srst_in (srst_in),
		.level_in(shift_clock_in),
		.rise_out(shift_rise)
	);

	edge_detect u_store_edge (
		.clk_in  (clk_in),
		.srst_in (srst_in),
		.level_in(storage_clock_in),
		.rise_out(store_rise)
	);

	// ------------------------------------------------------------
	// shift and storage registers
	// ------------------------------------------------------------
	reg  [STAGES-1:0] shift_q;
	reg  [STAGES-1:0] shift_d;
	reg  [STAGES-1:0] store_q;
	reg               dropped_q;

	always @* begin
		shift_d = shift_q;
		if (!shift_clear_n_in) begin
			shift_d = {STAGES{1'b0}};
		end else if (shift_rise) begin
			shift_d = {shift_q[STAGES-2:0], serial_in_in};
		end
	end

	always @(posedge clk_in) begin
		if (srst_in) begin
			shift_q   <= `SHIFT_RESET_VALUE;
			store_q   <= `STORE_RESET_VALUE;
			dropped_q <= 1'b0;
		end else begin
			shift_q <= shift_d;
			if (store_rise) begin
				store_q <= shift_q;
			end
			if (store_rise & ~fifo_in_ready) begin
				dropped_q <= 1'b1;
			end
		end
	end

	// clear is level-acting: a held-low clear shows on the cascade at once
	assign cascade_serial_out_out = shift_clear_n_in ? shift_q[STAGES-1] : 1'b0;

	// ------------------------------------------------------------
	// three-state parallel outputs
	// ------------------------------------------------------------
	assign parallel_out_out = store_q;
	assign parallel_oe_out  = {STAGES{~output_enable_n_in}};

	// ------------------------------------------------------------
	// stored word queue
	// ------------------------------------------------------------
	word_fifo #(
		.WIDTH (STAGES),
		.DEPTH (DEPTH),
		.AWIDTH(`FIFO_PTR_WIDTH)
	) u_fifo (
		.clk_in       (clk_in),
		.srst_in      (srst_in),
		.in_valid_in  (store_rise),
		.in_ready_out (fifo_in_ready),
		.in_data_in   (shift_q),
		.out_valid_out(word_valid_out),
		.out_ready_in (word_ready_in),
		.out_data_out (word_data_out)
	);

	assign word_dropped_out = dropped_q;
endmodule // serial_in_parallel_out_latch

// ---- rtl/sipo_latch_defines.vh ----
// Purpose: constants for the serial-in parallel-out latch
// Assumes: single 200 MHz clock, synchronous active-high reset
// Notes:   definitions only
`ifndef SIPO_LATCH_DEFINES_VH
`define SIPO_LATCH_DEFINES_VH

`define STAGE_COUNT        8
`define SHIFT_RESET_VALUE  8'h00
`define STORE_RESET_VALUE  8'h00
`define FIFO_DEPTH         8
`define FIFO_PTR_WIDTH     3
`define CLK_PERIOD_PS      5000
// least setup of a serial bit before its shift edge, in ps
`define SER_SETUP_PS       21000
`define SER_SETUP_CYCLES   ((`SER_SETUP_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)

`endif

// ---- rtl/edge_detect.v ----
// Purpose: rising-edge pulse from a sampled level
// Assumes: input synchronous to clk_in
// Notes:   one flop of history
`timescale 1ns/1ps
module edge_detect (
	// clock and reset
	input  wire clk_in,
	input  wire srst_in,
	// level in, pulse out
	input  wire level_in,
	output wire rise_out
);
	reg level_q;

	always @(posedge clk_in) begin
		if (srst_in) begin
			level_q <= 1'b0;
		end else begin
			level_q <= level_in;
		end
	end

	assign rise_out = level_in & ~level_q;
endmodule // edge_detect

// ---- rtl/word_fifo.v ----
// Purpose: small synchronous FIFO with valid/ready on both sides
// Assumes: single clock
// Notes:   read data come from a register
`timescale 1ns/1ps
module word_fifo #(
	parameter WIDTH  = 8,
	parameter DEPTH  = 8,
	parameter AWIDTH = 3
) (
	// clock and reset
	input  wire             clk_in,
	input  wire             srst_in,
	// fill side
	input  wire             in_valid_in,
	output wire             in_ready_out,
	input  wire [WIDTH-1:0] in_data_in,
	// drain side
	output wire             out_valid_out,
	input  wire             out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0]  mem_q [0:DEPTH-1];
	reg [AWIDTH-1:0] wr_ptr_q;
	reg [AWIDTH-1:0] rd_ptr_q;
	reg [AWIDTH:0]   count_q;
	reg [WIDTH-1:0]  head_q;
	reg              head_valid_q;

	wire push;
	wire pop_mem;
	wire head_load;

	// head register is refilled when it empties or is taken, if memory holds a word
	assign head_load    = (count_q != {(AWIDTH+1){1'b0}}) & (~head_valid_q | out_ready_in);
	assign pop_mem      = head_load;
	assign in_ready_out = (count_q != DEPTH[AWIDTH:0]);
	assign push         = in_valid_in & in_ready_out;

	always @(posedge clk_in) begin
		if (push) begin
			mem_q[wr_ptr_q] <= in_data_in;
		end
	end

	always @(posedge clk_in) begin
		if (srst_in) begin
			wr_ptr_q     <= {AWIDTH{1'b0}};
			rd_ptr_q     <= {AWIDTH{1'b0}};
			count_q      <= {(AWIDTH+1){1'b0}};
			head_q       <= {WIDTH{1'b0}};
			head_valid_q <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop_mem) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
				head_q   <= mem_q[rd_ptr_q];
			end
			case ({push, pop_mem})
				2'b10: count_q <= count_q + 1'b1;
				2'b01: count_q <= count_q - 1'b1;
				default: count_q <= count_q;
			endcase
			if (pop_mem) begin
				head_valid_q <= 1'b1;
			end else if (out_ready_in) begin
				head_valid_q <= 1'b0;
			end
		end
	end

	assign out_valid_out = head_valid_q;
	assign out_data_out  = head_q;
endmodule // word_fifo

// ---- tb/sipo_checker.sv ----
// Purpose: port checker for the latch
// Assumes: one clock, sync reset
// Notes:   bound to the top module
`timescale 1ns/1ps
module sipo_checker #(
	parameter STAGES = 8,
	parameter DEPTH  = 8
) (
	input wire              clk_in, srst_in, shift_clock_in, serial_in_in, shift_clear_n_in,
	input wire              storage_clock_in, output_enable_n_in, cascade_serial_out_out,
	input wire [STAGES-1:0] parallel_out_out, parallel_oe_out, word_data_out,
	input wire              word_valid_out, word_ready_in, word_dropped_out
);
	reg              sc_q;
	reg              rc_q;
	reg [STAGES-1:0] ref_q;
	// reference shift stages
	always @(posedge clk_in) begin
		sc_q <= srst_in ? 1'b0 : shift_clock_in;
		rc_q <= srst_in ? 1'b0 : storage_clock_in;
		if (srst_in || !shift_clear_n_in)
			ref_q <= '0;
		else if (shift_clock_in && !sc_q)
			ref_q <= {ref_q[STAGES-2:0], serial_in_in};
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	sequence st_s;
		storage_clock_in && !rc_q;
	endsequence
	sequence clr_st_s;
		!shift_clear_n_in ##1 st_s;
	endsequence
	a_oe_follows: assert property (parallel_oe_out == {STAGES{!output_enable_n_in}})
		else $error("enable mismatch");
	a_store_hold: assert property (!(storage_clock_in && !rc_q) |=> $stable(parallel_out_out))
		else $error("store without rise");
	a_store_copy: assert property (st_s |=> parallel_out_out == $past(ref_q))
		else $error("stored word wrong");
	a_cascade_last: assert property (shift_clear_n_in |-> cascade_serial_out_out == ref_q[STAGES-1])
		else $error("cascade wrong");
	a_clear_cascade: assert property (!shift_clear_n_in |-> !cascade_serial_out_out)
		else $error("cascade not cleared");
	a_clear_store: assert property (clr_st_s |=> parallel_out_out == '0)
		else $error("clear not stored");
	a_valid_hold: assert property (word_valid_out && !word_ready_in |=> word_valid_out && $stable(word_data_out))
		else $error("word not held");
	a_drop_sticky: assert property (word_dropped_out |=> word_dropped_out)
		else $error("drop flag lost");
endmodule // sipo_checker
bind serial_in_parallel_out_latch sipo_checker #(.STAGES(STAGES), .DEPTH(DEPTH)) chk_i (.*);

// ---- tb/word_sink.sv ----
// Purpose: consumer of the stored word stream
// Assumes: clk_in domain
// Notes:   stall_in holds ready low; counts the words it takes
`timescale 1ns/1ps
module word_sink (
	// clock and reset
	input  wire       clk_in,
	input  wire       srst_in,
	// stream handshake
	input  wire       stall_in,
	input  wire       valid_in,
	output wire       ready_out,
	// words taken since reset
	output reg  [7:0] taken_out
);
	assign ready_out = !stall_in;

	always @(posedge clk_in) begin
		if (srst_in) begin
			taken_out <= 8'h00;
		end else if (valid_in && ready_out) begin
			taken_out <= taken_out + 8'h01;
		end
	end
endmodule // word_sink

// ---- tb/serial_in_parallel_out_latch_tb.sv ----
// Purpose: self-checking bench for the latch
// Assumes: 200 MHz clock, inputs driven 1 ns after edge
// Notes:   table rows, then hand tests
`timescale 1ns/1ps
module serial_in_parallel_out_latch_tb;
	logic       clk_in = 0, srst_in = 1, sc = 0, si = 0, clr_n = 1, rc = 0, oe_n = 0, stall = 0;
	wire        cas, vld, rdy, drop;
	wire  [7:0] par, oe, dat, taken;
	int         n_mismatch = 0;
	int         checks = 0;
	// data, enable_n, parallel, pin enables, cascade
	logic [25:0] rows[4] = '{{8'ha5, 1'b0, 8'ha5, 8'hff, 1'b1}, {8'h3c, 1'b1, 8'h3c, 8'h00, 1'b0},
		{8'h01, 1'b0, 8'h01, 8'hff, 1'b0}, {8'hff, 1'b1, 8'hff, 8'h00, 1'b1}};
	serial_in_parallel_out_latch uut (.clk_in(clk_in), .srst_in(srst_in), .shift_clock_in(sc),
		.serial_in_in(si), .shift_clear_n_in(clr_n), .storage_clock_in(rc),
		.output_enable_n_in(oe_n), .cascade_serial_out_out(cas), .parallel_out_out(par),
		.parallel_oe_out(oe), .word_valid_out(vld), .word_ready_in(rdy), .word_data_out(dat),
		.word_dropped_out(drop));
	word_sink sink (.clk_in(clk_in), .srst_in(srst_in), .stall_in(stall), .valid_in(vld), .ready_out(rdy),
		.taken_out(taken));
	task tick;
		@(posedge clk_in);
		#1;
	endtask
	task sh(input logic b);
		sc = 1;
		si = b;
		tick;
		sc = 0;
		tick;
	endtask
	task ld(input logic [7:0] v);
		for (int i = 7; i >= 0; i--) sh(v[i]);
	endtask
	task st;
		rc = 1;
		tick;
		rc = 0;
		tick;
	endtask
	task chk(input logic [7:0] g, input logic [7:0] e);
		checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask
	task results;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial forever #2.5 clk_in = ~clk_in;
	initial begin
		repeat (20) tick;
		srst_in = 0;
		foreach (rows[i]) begin
			oe_n = rows[i][17];
			ld(rows[i][25:18]);
			st;
			chk(par, rows[i][16:9]);
			chk(oe, rows[i][8:1]);
			chk({7'h0, cas}, {7'h0, rows[i][0]});
			chk({7'h0, vld}, 8'h01);
			chk(dat, rows[i][16:9]);
		end
		$display("table done");
		clr_n = 0;
		sh(1);
		chk({7'h0, cas}, 8'h00);
		clr_n = 1;
		st;
		chk(par, 8'h00);
		$display("clear done");
		ld(8'h0f);
		sc = 1;
		rc = 1;
		si = 1;
		tick;
		sc = 0;
		rc = 0;
		tick;
		chk(par, 8'h0f);
		st;
		chk(par, 8'h1f);
		$display("shared edge done");
		chk({7'h0, drop}, 8'h00);
		stall = 1;
		repeat (10) st;
		chk({7'h0, drop}, 8'h01);
		stall = 0;
		for (int i = 0; i < 40 && vld; i++) tick;
		chk({7'h0, vld}, 8'h00);
		chk(taken, 8'h0f);
		$display("fifo done");
		ld(8'h80);
		st;
		srst_in = 1;
		tick;
		tick;
		chk(par, 8'h00);
		chk({7'h0, cas}, 8'h00);
		chk({7'h0, vld}, 8'h00);
		chk({7'h0, drop}, 8'h00);
		srst_in = 0;
		ld(8'hc3);
		st;
		chk(par, 8'hc3);
		chk({7'h0, cas}, 8'h01);
		$display("reset done");
		results;
	end
endmodule // serial_in_parallel_out_latch_tb
